// ### pkg/nbu_pkg.sv
// shared constants and types for the nine-bit serial port and baud logic
// assumes one core clock; register access is the 8-bit special-register port
package nbu_pkg;
    // register offsets
    localparam logic [7:0] ADDR_CONTROL = 8'h98;
    localparam logic [7:0] ADDR_BUFFER = 8'h99;
    localparam logic [7:0] ADDR_FRACTION = 8'h9d;
    localparam logic [7:0] ADDR_TIMER_CTL = 8'h9e;
    // serial_control fields
    localparam int CTL_MODE_HIGH = 7;
    localparam int CTL_MODE_LOW = 6;
    localparam int CTL_ADDR_FILTER = 5;
    localparam int CTL_RX_ENABLE = 4;
    localparam int CTL_TX_NINTH = 3;
    localparam int CTL_RX_NINTH = 2;
    localparam int CTL_TX_DONE = 1;
    localparam int CTL_RX_DONE = 0;
    // uart_timer_fraction fields
    localparam int FRAC_SELECT = 7;
    localparam int FRAC_MSB = 5;
    // uart_timer_control fields
    localparam int TCTL_FRAMING = 6;
    localparam int TCTL_BREAK = 5;
    localparam int TCTL_EXT_MSB = 4;
    localparam int TCTL_EXT_LSB = 3;
    localparam int TCTL_DIV_MSB = 2;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [15:0] RST_TIMER2 = 16'h0000;
    // timing counts in core clocks and ticks
    localparam logic [3:0] SHIFT_DIV_LAST = 4'hb;
    localparam logic [3:0] OS_LAST = 4'hf;
    localparam logic [3:0] OS_MID = 4'h7;
    localparam logic [6:0] FRAC_UNIT = 7'h40;
    localparam logic [3:0] BITS_SHIFT = 4'h8;
    localparam logic [3:0] BITS_EIGHT = 4'ha;
    localparam logic [3:0] BITS_NINE = 4'hb;
    localparam logic [3:0] RX_LAST_EIGHT = 4'h8;
    localparam logic [3:0] RX_LAST_NINE = 4'h9;
    localparam logic [3:0] RX_LAST_SHIFT = 4'h7;

    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} nbu_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SHIFT}
        nbu_rx_st_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nbu_sfr_req_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } nbu_t2_reload_t;

    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] rxbuf;
        logic uts;
        logic [5:0] frac;
        logic [2:0] div;
        logic [1:0] ext;
        logic fe;
        logic be;
        logic ovw;
        logic [7:0] rdata;
        logic s1;
        logic s2;
        logic sprev;
        logic [3:0] m0cnt;
        logic m2ph;
        logic t1half;
        logic t2ph;
        logic [15:0] t2cnt;
        logic [9:0] upre;
        logic [6:0] uacc;
        logic [3:0] txdiv;
        nbu_tx_st_t txst;
        logic [10:0] txsh;
        logic [3:0] txcnt;
        logic txd;
        nbu_rx_st_t rxst;
        logic [3:0] rxdiv;
        logic [9:0] rxsh;
        logic [3:0] rxcnt;
        logic rxzero;
    } nbu_state_t;
endpackage

// ### hdl/nbu_uart.sv
// nine-bit serial port with its baud sources and enhanced receive checks
// assumes firmware on the special-register port, clocked by the core clock;
// timer 1 overflow arrives as a one-cycle pulse from the timer block
//
// What this block does
// - mode high set, low clear: nine-bit fixed
// - fixed rate clock/32, or /16 when doubled
// - frame is start, eight data, ninth, stop
// - load buffer lsb first, ninth bit next
// - buffer write starts send at next bit boundary
// - set transmit done as stop bit appears
// - plain port keeps frame only if unread clear
// - address filter keeps only ninth-bit-one frames
// - failed check drops frame, receive flag untouched
// - accepted frame fills buffer, ninth, receive flag
// - both mode bits: nine-bit with timer rate
// - shift mode starts on enable, else start bit
// - shift mode rate is clock/12 always
// - timer 1 rate, doubled by doubler, /32
// - timer 2 selects per direction, /16 rate
// - timer 2 advances every two clocks
// - uart timer exponents from control bits
// - uart timer clock/16/2^exp/(1+frac/64)
// - enhanced: missing stop bit flags framing
// - enhanced: line low whole frame flags break
// - enhanced: unread overwritten byte flags overwrite
// - eight-bit filter blocks stopless frames, keeps stop
// - uart timer select overrides doubler, timer 2 outside mode 2
// - enhanced checks only with enhanced bit set
// - framing flag is timer control bit 6
// - break flag is timer control bit 5
module nbu_uart
(
    input wire logic clk,
    input wire logic resetn,
    input wire nbu_pkg::nbu_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic baud_doubler,
    input wire logic enhanced_uart_on,
    input wire logic timer1_overflow,
    input wire logic timer2_rx_select,
    input wire logic timer2_tx_select,
    input wire nbu_pkg::nbu_t2_reload_t timer2_reload,
    input wire logic rxd,
    output logic txd,
    output logic overwrite_flag
);
    nbu_pkg::nbu_state_t st;
    nbu_pkg::nbu_state_t next_st;
    logic [1:0] mode;
    logic m0p;
    logic m2t;
    logic t1t;
    logic t2run;
    logic t2ov;
    logic upre_p;
    logic utt;
    logic [7:0] uacc_sum;
    logic txt;
    logic rxt;
    logic txb;
    logic wr_buf;
    logic wr_ctl;
    logic [9:0] nsh;
    logic rx_final;
    logic [7:0] rx_data;
    logic rx_ninth;
    logic rx_stop;
    logic accept;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // one tick source per direction; mode 2 ignores the timers
    function automatic logic sel_tick(input logic [1:0] m, input logic uts,
                                      input logic t2sel, input logic fixed,
                                      input logic ut, input logic t2,
                                      input logic t1);
        if (m == 2'b10)
            sel_tick = fixed;
        else if (uts)
            sel_tick = ut;
        else if (t2sel)
            sel_tick = t2;
        else
            sel_tick = t1;
    endfunction

    assign mode = {st.ctl[nbu_pkg::CTL_MODE_HIGH],
                   st.ctl[nbu_pkg::CTL_MODE_LOW]};
    assign wr_buf = sfr_req.wr && sfr_req.addr == nbu_pkg::ADDR_BUFFER;
    assign wr_ctl = sfr_req.wr && sfr_req.addr == nbu_pkg::ADDR_CONTROL;

    // tick generators
    assign m0p = st.m0cnt == nbu_pkg::SHIFT_DIV_LAST;
    assign m2t = baud_doubler | st.m2ph;
    assign t1t = timer1_overflow & (baud_doubler | st.t1half);
    assign t2run = !st.uts && (timer2_rx_select || timer2_tx_select);
    assign t2ov = t2run && st.t2ph && st.t2cnt == 16'hffff;
    assign upre_p = st.upre
        == 10'((11'h001 << ({1'b0, st.div} + {2'h0, st.ext})) - 11'h001);
    assign uacc_sum = {1'b0, st.uacc} + {1'b0, nbu_pkg::FRAC_UNIT};
    // fractional step: one tick per (64 + frac)/64 prescaled pulses
    assign utt = upre_p
        && uacc_sum >= {1'b0, nbu_pkg::FRAC_UNIT} + {2'h0, st.frac};
    assign txt = sel_tick(mode, st.uts, timer2_tx_select, m2t, utt, t2ov, t1t);
    assign rxt = sel_tick(mode, st.uts, timer2_rx_select, m2t, utt, t2ov, t1t);
    assign txb = mode == 2'b00 ? m0p : txt && st.txdiv == nbu_pkg::OS_LAST;

    // receive sampling
    assign nsh = {st.s2, st.rxsh[9:1]};
    assign rx_final = (st.rxst == nbu_pkg::RX_DATA && rxt
                       && st.rxdiv == nbu_pkg::OS_LAST
                       && st.rxcnt == (mode == 2'b01 ? nbu_pkg::RX_LAST_EIGHT
                                                    : nbu_pkg::RX_LAST_NINE))
        || (st.rxst == nbu_pkg::RX_SHIFT && m0p
            && st.rxcnt == nbu_pkg::RX_LAST_SHIFT);
    assign rx_data = mode == 2'b00 ? nsh[9:2]
                   : mode == 2'b01 ? nsh[8:1] : nsh[7:0];
    assign rx_stop = nsh[9];
    assign rx_ninth = mode == 2'b01 ? nsh[9] : nsh[8];
    assign accept = rx_final && (enhanced_uart_on
                                 || !st.ctl[nbu_pkg::CTL_RX_DONE])
        && (mode == 2'b00 || !st.ctl[nbu_pkg::CTL_ADDR_FILTER]
            || rx_ninth);

    always_comb
    begin
        next_st = st;
        // register writes; hardware sets below win over them
        if (wr_ctl)
            next_st.ctl = sfr_req.wdata;
        if (sfr_req.wr && sfr_req.addr == nbu_pkg::ADDR_FRACTION)
        begin
            next_st.uts = sfr_req.wdata[nbu_pkg::FRAC_SELECT];
            next_st.frac = sfr_req.wdata[nbu_pkg::FRAC_MSB:0];
        end
        if (sfr_req.wr && sfr_req.addr == nbu_pkg::ADDR_TIMER_CTL)
        begin
            next_st.div = sfr_req.wdata[nbu_pkg::TCTL_DIV_MSB:0];
            next_st.ext = sfr_req.wdata[nbu_pkg::TCTL_EXT_MSB:
                                        nbu_pkg::TCTL_EXT_LSB];
        end
        if (sfr_req.rd)
        begin
            case (sfr_req.addr)
                nbu_pkg::ADDR_CONTROL: next_st.rdata = st.ctl;
                nbu_pkg::ADDR_BUFFER: next_st.rdata = st.rxbuf;
                nbu_pkg::ADDR_FRACTION: next_st.rdata = {st.uts, 1'b0, st.frac};
                nbu_pkg::ADDR_TIMER_CTL: next_st.rdata = {1'b0, st.fe, st.be,
                    st.ext, st.div};
                default: next_st.rdata = nbu_pkg::RST_REG;
            endcase
            if (sfr_req.addr == nbu_pkg::ADDR_BUFFER)
                next_st.ovw = 1'b0;
        end
        // pin synchroniser; second stage and the edge stage after it are read
        next_st.s1 = rxd;
        next_st.s2 = st.s1;
        next_st.sprev = st.s2;
        // baud sources
        next_st.m0cnt = m0p ? 4'h0 : st.m0cnt + 4'h1;
        next_st.m2ph = !st.m2ph;
        if (timer1_overflow)
            next_st.t1half = !st.t1half;
        if (t2run)
        begin
            next_st.t2ph = !st.t2ph;
            if (t2ov)
                next_st.t2cnt = {timer2_reload.high, timer2_reload.low};
            else if (st.t2ph)
                next_st.t2cnt = st.t2cnt + 16'h0001;
        end
        else // idle timer holds its reload so the first period is full
            next_st.t2cnt = {timer2_reload.high, timer2_reload.low};
        next_st.upre = upre_p ? 10'h000 : st.upre + 10'h001;
        if (upre_p)
            next_st.uacc = utt ? 7'(uacc_sum - {2'h0, nbu_pkg::FRAC_UNIT}
                                    - {2'h0, st.frac})
                               : uacc_sum[6:0];
        // transmitter
        if (txt)
            next_st.txdiv = st.txdiv + 4'h1;
        case (st.txst)
            nbu_pkg::TX_IDLE: next_st.txd = 1'b1;
            nbu_pkg::TX_WAIT,
            nbu_pkg::TX_SHIFT:
                if (txb)
                begin
                    if (st.txcnt == 4'h0)
                        next_st.txst = nbu_pkg::TX_IDLE;
                    else
                    begin
                        next_st.txst = nbu_pkg::TX_SHIFT;
                        next_st.txd = st.txsh[0];
                        next_st.txsh = {1'b1, st.txsh[10:1]};
                        next_st.txcnt = st.txcnt - 4'h1;
                        if (st.txcnt == 4'h1)
                            next_st.ctl[nbu_pkg::CTL_TX_DONE] = 1'b1;
                    end
                end
            default: next_st.txst = nbu_pkg::TX_IDLE;
        endcase
        // a write while busy restarts the frame rather than queue it
        if (wr_buf)
        begin
            next_st.txst = nbu_pkg::TX_WAIT;
            case (mode)
                2'b00:
                begin
                    next_st.txsh = {3'b111, sfr_req.wdata};
                    next_st.txcnt = nbu_pkg::BITS_SHIFT;
                end
                2'b01:
                begin
                    next_st.txsh = {2'b11, sfr_req.wdata, 1'b0};
                    next_st.txcnt = nbu_pkg::BITS_EIGHT;
                end
                default:
                begin
                    next_st.txsh = {1'b1, st.ctl[nbu_pkg::CTL_TX_NINTH],
                                    sfr_req.wdata, 1'b0};
                    next_st.txcnt = nbu_pkg::BITS_NINE;
                end
            endcase
        end
        // receiver
        case (st.rxst)
            nbu_pkg::RX_IDLE:
            begin
                next_st.rxcnt = 4'h0;
                next_st.rxdiv = 4'h0;
                next_st.rxzero = 1'b1;
                if (st.ctl[nbu_pkg::CTL_RX_ENABLE])
                begin
                    if (mode == 2'b00 && !st.ctl[nbu_pkg::CTL_RX_DONE])
                        next_st.rxst = nbu_pkg::RX_SHIFT;
                    else if (mode != 2'b00 && st.sprev && !st.s2)
                        next_st.rxst = nbu_pkg::RX_START;
                end
            end
            nbu_pkg::RX_START:
                if (rxt)
                begin
                    next_st.rxdiv = st.rxdiv + 4'h1;
                    if (st.rxdiv == nbu_pkg::OS_MID)
                    begin
                        // a glitch shorter than half a bit is not a start
                        next_st.rxst = st.s2 ? nbu_pkg::RX_IDLE
                                             : nbu_pkg::RX_DATA;
                        next_st.rxdiv = 4'h0;
                    end
                end
            nbu_pkg::RX_DATA:
                if (rxt)
                begin
                    next_st.rxdiv = st.rxdiv + 4'h1;
                    if (st.rxdiv == nbu_pkg::OS_LAST)
                    begin
                        next_st.rxsh = nsh;
                        next_st.rxzero = st.rxzero & !st.s2;
                        next_st.rxcnt = st.rxcnt + 4'h1;
                    end
                end
            nbu_pkg::RX_SHIFT:
                if (m0p)
                begin
                    next_st.rxsh = nsh;
                    next_st.rxcnt = st.rxcnt + 4'h1;
                end
            default: next_st.rxst = nbu_pkg::RX_IDLE;
        endcase
        if (rx_final)
        begin
            next_st.rxst = nbu_pkg::RX_IDLE;
            if (mode != 2'b00 && enhanced_uart_on)
            begin
                next_st.fe = !rx_stop;
                next_st.be = st.rxzero & !st.s2;
            end
            if (accept)
            begin
                next_st.rxbuf = rx_data;
                next_st.ctl[nbu_pkg::CTL_RX_NINTH] = rx_ninth;
                next_st.ctl[nbu_pkg::CTL_RX_DONE] = 1'b1;
                if (enhanced_uart_on && st.ctl[nbu_pkg::CTL_RX_DONE])
                    next_st.ovw = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.txd <= 1'b1;
            st.s1 <= 1'b1;
            st.s2 <= 1'b1;
            st.sprev <= 1'b1;
            st.ctl <= nbu_pkg::RST_REG;
            st.t2cnt <= nbu_pkg::RST_TIMER2;
        end
        else
            st <= next_st;
    end

    assign sfr_rdata = st.rdata;
    assign txd = st.txd;
    assign overwrite_flag = st.ovw;

    // checks
    sequence s_buf_write;
        wr_buf;
    endsequence
    sequence s_waits_for_tick;
        st.txst == nbu_pkg::TX_WAIT && st.txd == $past(st.txd);
    endsequence

    a_tx_waits_tick: assert property (
        s_buf_write |=> s_waits_for_tick)
        else $error("transmit started before a baud tick");
    a_tx_start_low: assert property (
        st.txst == nbu_pkg::TX_WAIT && txb && !wr_buf && mode != 2'b00
        |=> !st.txd)
        else $error("frame did not open with a start bit");
    a_ti_on_stop: assert property (
        $rose(st.ctl[nbu_pkg::CTL_TX_DONE]) && !$past(wr_ctl) && mode != 2'b00
        |-> st.txd && st.txcnt == 4'h0)
        else $error("transmit done not aligned with stop bit");
    a_rx_keep_unread: assert property (
        rx_final && !enhanced_uart_on && st.ctl[nbu_pkg::CTL_RX_DONE]
        |=> $stable(st.rxbuf))
        else $error("unread byte overwritten");
    a_rx_addr_filter: assert property (
        rx_final && mode[1] && st.ctl[nbu_pkg::CTL_ADDR_FILTER] && !rx_ninth
        && !wr_ctl |=> $stable(st.ctl[nbu_pkg::CTL_RX_DONE]))
        else $error("filtered frame raised receive done");
    a_rx_accept_load: assert property (
        accept |=> st.ctl[nbu_pkg::CTL_RX_DONE]
        && st.rxbuf == $past(rx_data))
        else $error("accepted frame not stored");
    a_fixed_half_rate: assert property (
        mode == 2'b10 && !baud_doubler && txt
        |=> !txt)
        else $error("fixed rate tick too fast");
    a_shift_rate: assert property (
        m0p |-> ##12 m0p)
        else $error("shift mode rate is not clock/12");
    a_t2_two_clocks: assert property (
        t2run && $changed(st.t2cnt) && !t2ov |=> $stable(st.t2cnt))
        else $error("timer 2 advanced on consecutive clocks");
    a_frame_error: assert property (
        rx_final && enhanced_uart_on && mode != 2'b00 && !rx_stop
        |=> st.fe)
        else $error("missing stop bit not flagged");
    a_overwrite_flag: assert property (
        accept && enhanced_uart_on && st.ctl[nbu_pkg::CTL_RX_DONE]
        |=> overwrite_flag)
        else $error("overwrite not flagged");
    a_rx_eight_stop: assert property (
        rx_final && mode == 2'b01 && st.ctl[nbu_pkg::CTL_ADDR_FILTER]
        && !rx_ninth && !wr_ctl |=> $stable(st.ctl[nbu_pkg::CTL_RX_DONE]))
        else $error("stopless frame passed the eight-bit filter");
    a_enh_off_keeps: assert property (
        rx_final && !enhanced_uart_on |=> $stable(st.fe) && $stable(st.be))
        else $error("fault flags moved with enhanced checks off");
    a_shift_rx_start: assert property (
        st.rxst == nbu_pkg::RX_IDLE && mode == 2'b00
        && st.ctl[nbu_pkg::CTL_RX_ENABLE] && !st.ctl[nbu_pkg::CTL_RX_DONE]
        |=> st.rxst == nbu_pkg::RX_SHIFT)
        else $error("shift receive did not start");
    a_t2_reload: assert property (
        t2ov |=> st.t2cnt == $past(timer2_reload))
        else $error("timer 2 did not reload");
    a_break_flag: assert property (
        rx_final && enhanced_uart_on && mode != 2'b00 && st.rxzero && !st.s2
        |=> st.be)
        else $error("all-low frame not flagged as break");
endmodule // nbu_uart

// ### tb/nbu_station.sv
// remote serial station model on the port's transmit and receive lines
// assumes bit times given in core clocks; line sampled on falling edges
module nbu_station
(
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    int run = 0;
    int last_low = 0;

    initial rxd = 1'b1;

    // latest low run on txd, so the bench can time bits
    always @(negedge clk)
    begin
        if (txd === 1'b0)
            run <= run + 1;
        else
        begin
            if (run != 0)
                last_low <= run;
            run <= 0;
        end
    end

    // stop low makes a framing fault; all low makes a break
    task automatic send(input int bt, input logic [7:0] d,
        input logic ninth, input logic stop);
        logic [10:0] frame;
        frame = {stop, ninth, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            @(negedge clk);
            rxd = frame[i];
            repeat (bt - 1) @(negedge clk);
        end
        @(negedge clk);
        rxd = 1'b1;
        repeat (bt) @(negedge clk);
    endtask

    // bit centres taken from the start edge; ok low if no frame began
    task automatic recv(input int bt, output logic [10:0] fr,
        output logic ok);
        ok = 1'b0;
        fr = '0;
        for (int w = 0; w < 4000 && !ok; w++)
        begin
            @(negedge clk);
            ok = (txd === 1'b0);
        end
        if (ok)
        begin
            repeat (bt / 2) @(negedge clk);
            for (int i = 0; i < 11; i++)
            begin
                fr[i] = txd;
                repeat (bt) @(negedge clk);
            end
        end
    endtask
endmodule // nbu_station

// ### tb/tb.sv
// self-checking bench for the nine-bit serial port
// assumes the station model on the serial lines and a 25 MHz core clock
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic resetn;
    nbu_pkg::nbu_sfr_req_t sfr_req;
    logic [7:0] sfr_rdata;
    logic baud_doubler;
    logic enhanced_uart_on;
    logic timer1_overflow = 1'b0;
    logic timer2_rx_select;
    logic timer2_tx_select;
    nbu_pkg::nbu_t2_reload_t timer2_reload;
    logic rxd;
    logic txd;
    logic overwrite_flag;
    logic t1_run;
    logic [1:0] t1_cnt = 2'h0;
    logic [7:0] rv;
    logic [10:0] fr;
    logic ok;
    int n1;
    int n2;
    int mismatches = 0;
    int checks = 0;
    logic [7:0] regs [5] = '{8'h98, 8'h99, 8'h9d, 8'h9e, 8'h9a};

    nbu_uart nbu_uart_i
    (
        .clk(clk),
        .resetn(resetn),
        .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata),
        .baud_doubler(baud_doubler),
        .enhanced_uart_on(enhanced_uart_on),
        .timer1_overflow(timer1_overflow),
        .timer2_rx_select(timer2_rx_select),
        .timer2_tx_select(timer2_tx_select),
        .timer2_reload(timer2_reload),
        .rxd(rxd),
        .txd(txd),
        .overwrite_flag(overwrite_flag)
    );

    nbu_station nbu_station_i
    (
        .clk(clk),
        .txd(txd),
        .rxd(rxd)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // timer 1 overflow pulse every four clocks while enabled
    always @(negedge clk)
    begin
        t1_cnt <= t1_cnt + 2'h1;
        timer1_overflow <= t1_run && t1_cnt == 2'h3;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic timeout();
        mismatches++;
        $display("BAD %0t wait ran out", $time);
        conclude();
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_req = {1'b1, 1'b0, a, d};
        @(negedge clk);
        sfr_req.wr = 1'b0;
    endtask

    // read data is registered, settled one cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        sfr_req = {1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        sfr_req.rd = 1'b0;
        d = sfr_rdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        rd(a, rv);
        chk(32'(rv), 32'(e));
    endtask

    task automatic rx(input logic [7:0] d, input logic n, input logic s);
        nbu_station_i.send(16, d, n, s);
    endtask

    // mode 2 doubled: sixteen clocks a bit
    task automatic tx_case(input logic [7:0] ctl, input logic [7:0] d);
        wr(8'h98, ctl);
        wr(8'h99, d);
        nbu_station_i.recv(16, fr, ok);
        if (!ok)
            timeout();
        chk(32'(fr), 32'({1'b1, ctl[3], d, 1'b0}));
        rdchk(8'h98, ctl | 8'h02);
    endtask

    // data 0x95 ends its last low run two bits long before done is set
    task automatic rate(input logic [7:0] ctl, input int bt, output int n);
        logic [7:0] c;
        c = 8'h00;
        wr(8'h98, ctl);
        wr(8'h99, 8'h95);
        for (int i = 0; i < 1000 && c[1] !== 1'b1; i++)
            rd(8'h98, c);
        if (c[1] !== 1'b1)
            timeout();
        n = nbu_station_i.last_low;
        repeat (n) @(negedge clk);
        if (bt > 0)
            chk(32'(n), 32'(2 * bt));
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        timeout();
    end

    initial
    begin
        resetn = 1'b0;
        sfr_req = '0;
        baud_doubler = 1'b1;
        enhanced_uart_on = 1'b0;
        timer2_rx_select = 1'b0;
        timer2_tx_select = 1'b0;
        // set before timer 2 first runs, so its first period is full
        timer2_reload = 16'hfffe;
        t1_run = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        chk(32'(txd), 32'h1);
        foreach (regs[i])
            rdchk(regs[i], 8'h00);
        chk(32'(overwrite_flag), 32'h0);
        wr(8'h9e, 8'hff);
        rdchk(8'h9e, 8'h1f);
        wr(8'h9d, 8'hff);
        rdchk(8'h9d, 8'hbf);
        wr(8'h9e, 8'h00);
        wr(8'h9d, 8'h00);
        $display("test registers done");
        tx_case(8'h88, 8'ha3);
        tx_case(8'h80, 8'h3c);
        $display("test transmit frame done");
        rate(8'h88, 16, n1);
        baud_doubler = 1'b0;
        rate(8'h88, 32, n1);
        rate(8'h00, 12, n1);
        baud_doubler = 1'b1;
        timer2_tx_select = 1'b1;
        wr(8'h9e, 8'h09);
        wr(8'h9d, 8'h80);
        rate(8'hc8, 64, n1);
        wr(8'h9e, 8'h00);
        wr(8'h9d, 8'ha0);
        rate(8'hc8, 24, n1);
        wr(8'h9d, 8'h00);
        timer2_tx_select = 1'b0;
        t1_run = 1'b1;
        rate(8'hc8, 64, n1);
        baud_doubler = 1'b0;
        rate(8'hc8, 128, n1);
        t1_run = 1'b0;
        timer2_tx_select = 1'b1;
        timer2_reload = 16'hfffe;
        rate(8'hc8, 0, n1);
        timer2_reload = 16'hfffc;
        rate(8'hc8, 0, n2);
        chk(32'(n2), 32'(2 * n1));
        timer2_tx_select = 1'b0;
        baud_doubler = 1'b1;
        $display("test bit rates done");
        wr(8'h98, 8'h90);
        rx(8'h3c, 1'b1, 1'b1);
        rdchk(8'h98, 8'h95);
        rdchk(8'h99, 8'h3c);
        rx(8'hc3, 1'b0, 1'b1);
        rdchk(8'h98, 8'h95);
        rdchk(8'h99, 8'h3c);
        chk(32'(overwrite_flag), 32'h0);
        enhanced_uart_on = 1'b1;
        rx(8'hc3, 1'b0, 1'b1);
        chk(32'(overwrite_flag), 32'h1);
        rdchk(8'h99, 8'hc3);
        chk(32'(overwrite_flag), 32'h0);
        rdchk(8'h98, 8'h91);
        $display("test receive accept done");
        wr(8'h98, 8'hb0);
        rx(8'h11, 1'b0, 1'b1);
        rdchk(8'h98, 8'hb0);
        rx(8'h22, 1'b1, 1'b1);
        rdchk(8'h98, 8'hb5);
        rdchk(8'h99, 8'h22);
        $display("test address filter done");
        wr(8'h98, 8'h90);
        rx(8'hff, 1'b1, 1'b0);
        rdchk(8'h9e, 8'h40);
        rx(8'h00, 1'b0, 1'b0);
        rdchk(8'h9e, 8'h60);
        rx(8'h5a, 1'b1, 1'b1);
        rdchk(8'h9e, 8'h00);
        enhanced_uart_on = 1'b0;
        rx(8'hff, 1'b1, 1'b0);
        rdchk(8'h9e, 8'h00);
        $display("test receive faults done");
        wr(8'h98, 8'h10);
        repeat (120) @(negedge clk);
        rdchk(8'h99, 8'hff);
        rd(8'h98, rv);
        chk(32'(rv[0]), 32'h1);
        t1_run = 1'b1;
        wr(8'h98, 8'h70);
        nbu_station_i.send(64, 8'h5a, 1'b0, 1'b1);
        rdchk(8'h98, 8'h70);
        nbu_station_i.send(64, 8'ha5, 1'b1, 1'b1);
        rdchk(8'h98, 8'h75);
        rdchk(8'h99, 8'ha5);
        $display("test shift and eight-bit receive done");
        conclude();
    end
endmodule // tb
